// >>> mfe_core.v
// Behaviour
// - Change-data-field loads operand field from buffer bit 8
// - Operand field holds until changed or interrupt
// - Change-code-field loads pending buffer, not code field
// - Jump or call copies pending into code field
// - Read operand field into AC8, clear AC6-7
// - Read code field into AC8, clear AC6-7
// - Read saved fields into AC8 and AC11
// - Restore: saved bits into pending and operand
// - Decode only in fetch with opcode six
// - Fetch and direct operands use code field
// - Operand field only in execute after defer
// - Indirect pointer read from code field
// - Autoindex words 10-17 in code field
// - Jump and call leave operand field alone
// - Code field is address msb above PC
// - Block interrupts after change-code until jump or call
// - Interrupt saves fields, then clears them
// - Interrupt stores PC at field-0 0000
// - Break extension selects break transfer field
// - Select code 2X on bits 3-5 only
// - Saved read keeps AC0-5, clears 6,7,9,10
// - Break strobe loads break field register
`timescale 1ns/1ps
`default_nettype none
`include "mfe_map.vh"

module mfe_core (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [2:0] opcode_register,
  input wire [11:0] memory_buffer,
  input wire [11:0] working_register,
  input wire [11:0] program_counter,
  input wire [11:0] mem_addr,
  input wire cycle_fetch,
  input wire cycle_defer,
  input wire cycle_execute,
  input wire cycle_break,
  input wire io_pulse,
  input wire jump_op_done,
  input wire subroutine_call_op_done,
  input wire interrupt_entry,
  input wire break_load_strobe,
  input wire break_addr_ext,
  output reg [11:0] ac_result,
  output reg ac_result_load,
  output reg field_select,
  output reg [12:0] ext_mem_addr,
  output reg [12:0] ext_inst_addr,
  output reg autoindex_access,
  output reg interrupt_block,
  output reg [12:0] pc_store_addr,
  output reg [12:0] pc_resume_addr
);

  // ------------------------------------------------------------
  // Field state
  // ------------------------------------------------------------
  reg instruction_field_reg; // Code field, msb above PC
  reg operand_field_reg; // Data field for indirect operands
  reg pending_field_buffer; // Next code field, taken on jump
  reg [1:0] saved_field_pair; // Bit 0 code, bit 1 data
  reg dma_field_reg; // Field of the break transfer
  reg after_defer; // Defer seen since last fetch
  reg io_enable; // Software gate on the decoder

  // ------------------------------------------------------------
  // Bus holding state
  // ------------------------------------------------------------
  reg aw_full; // Write address held
  reg w_full; // Write data held
  reg [7:0] aw_addr_q; // Held write address
  reg [31:0] w_data_q; // Held write data
  reg [3:0] w_strb_q; // Held byte enables

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  // Field bit into AC8, AC6-7 cleared, rest fed back
  function [11:0] ac_with_field;
    input [11:0] ac;
    input fld;
    begin
      ac_with_field = ac;
      ac_with_field[`MFE_AC_CLR_HI:`MFE_AC_CLR_LO] = 2'h0;
      ac_with_field[`MFE_AC_FIELD] = fld;
    end
  endfunction

  // Register read decode, shared by no other path but kept apart
  function [31:0] reg_read;
    input [7:0] addr;
    begin
      reg_read = `MFE_WORD0;
      if (addr == `MFE_REG_STATUS) begin
        reg_read[7:0] = {after_defer, interrupt_block, dma_field_reg,
          saved_field_pair, pending_field_buffer, operand_field_reg,
          instruction_field_reg};
      end else if (addr == `MFE_REG_CTRL) begin
        reg_read[`MFE_CTRL_IO_EN] = io_enable;
      end else if (addr == `MFE_REG_LOAD) begin
        reg_read[`MFE_LD_CODE] = instruction_field_reg;
        reg_read[`MFE_LD_DATA] = operand_field_reg;
      end
    end
  endfunction

  // Address decode validity
  function addr_known;
    input [7:0] addr;
    begin
      if (addr == `MFE_REG_LOAD) begin
        addr_known = 1'b1;
      end else if (addr == `MFE_REG_STATUS) begin
        addr_known = 1'b1;
      end else if (addr == `MFE_REG_CTRL) begin
        addr_known = 1'b1;
      end else begin
        addr_known = 1'b0;
      end
    end
  endfunction

  // ------------------------------------------------------------
  // Opcode decode
  // ------------------------------------------------------------
  wire [2:0] iop_bits = memory_buffer[`MFE_IOP_HI:`MFE_IOP_LO];
  wire [2:0] field_num = memory_buffer[`MFE_NUM_HI:`MFE_NUM_LO];
  wire field_bit = memory_buffer[`MFE_FN_BIT];
  // Bits 6-8 carry the field number, so they never select
  wire dev_hit = memory_buffer[`MFE_SEL_HI:`MFE_SEL_LO] == `MFE_DEV_SEL;
  // Only fetch with an I/O op in the opcode register may act
  wire io_go = io_pulse & cycle_fetch & io_enable & dev_hit &
    (opcode_register == `MFE_OP_IO);
  wire do_data_chg = io_go & iop_bits[`MFE_IOP_DATA];
  wire do_code_chg = io_go & iop_bits[`MFE_IOP_CODE];
  wire do_read = io_go & (iop_bits == `MFE_IOP_READ);
  wire do_restore = do_read & (field_num == `MFE_RESTORE);
  wire jump_any = jump_op_done | subroutine_call_op_done;

  // ------------------------------------------------------------
  // Bus write commit
  // ------------------------------------------------------------
  wire wr_go = aw_full & w_full & ~s_axi_bvalid;
  wire wr_lane0 = wr_go & w_strb_q[0];
  wire load_wr = wr_lane0 & (aw_addr_q == `MFE_REG_LOAD);
  wire ctrl_wr = wr_lane0 & (aw_addr_q == `MFE_REG_CTRL);

  // ------------------------------------------------------------
  // Field registers
  // ------------------------------------------------------------
  // Interrupt entry outranks everything; console load next
  always @(posedge aclk) begin
    if (!aresetn) begin
      instruction_field_reg <= `MFE_FIELD0;
      operand_field_reg <= `MFE_FIELD0;
      pending_field_buffer <= `MFE_FIELD0;
      saved_field_pair <= `MFE_SF_RESET;
    end else if (interrupt_entry) begin
      // Save both fields, then run the handler in field 0
      saved_field_pair <= {operand_field_reg, instruction_field_reg};
      instruction_field_reg <= `MFE_FIELD0;
      operand_field_reg <= `MFE_FIELD0;
      // Forced call would otherwise copy a stale buffer in
      pending_field_buffer <= `MFE_FIELD0;
    end else if (load_wr) begin
      // Console-style load bypasses the buffer
      instruction_field_reg <= w_data_q[`MFE_LD_CODE];
      pending_field_buffer <= w_data_q[`MFE_LD_CODE];
      operand_field_reg <= w_data_q[`MFE_LD_DATA];
    end else begin
      // Data field is not touched by jumps
      if (jump_any) begin
        instruction_field_reg <= pending_field_buffer;
      end
      if (do_data_chg) begin
        operand_field_reg <= field_bit;
      end
      if (do_code_chg) begin
        pending_field_buffer <= field_bit;
      end
      if (do_restore) begin
        pending_field_buffer <= saved_field_pair[0];
        operand_field_reg <= saved_field_pair[1];
      end
    end
  end

  // ------------------------------------------------------------
  // Break field register
  // ------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      dma_field_reg <= `MFE_FIELD0;
    end else if (break_load_strobe) begin
      dma_field_reg <= break_addr_ext;
    end
  end

  // ------------------------------------------------------------
  // Interrupt block after change-code
  // ------------------------------------------------------------
  // Set wins: a change-code in the jump cycle stays armed
  always @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_block <= 1'b0;
    end else if (do_code_chg) begin
      interrupt_block <= 1'b1;
    end else if (jump_any) begin
      interrupt_block <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Cycle tracking
  // ------------------------------------------------------------
  // Remembers a defer so the next execute uses the data field
  always @(posedge aclk) begin
    if (!aresetn) begin
      after_defer <= 1'b0;
    end else if (cycle_defer) begin
      after_defer <= 1'b1;
    end else if (cycle_fetch) begin
      after_defer <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Field selection for memory
  // ------------------------------------------------------------
  // Break first, then execute-after-defer, else code field.
  // Defer itself reads the pointer from the code field.
  reg next_field;
  always @* begin
    next_field = instruction_field_reg;
    if (cycle_break) begin
      next_field = dma_field_reg;
    end else if (cycle_execute & after_defer) begin
      next_field = operand_field_reg;
    end
  end

  // Registered address outputs, one cycle behind their inputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      field_select <= `MFE_FIELD0;
      ext_mem_addr <= `MFE_PC_STORE;
      ext_inst_addr <= `MFE_PC_STORE;
      autoindex_access <= 1'b0;
      pc_store_addr <= `MFE_PC_STORE;
      pc_resume_addr <= `MFE_PC_RESUME;
    end else begin
      field_select <= next_field;
      ext_mem_addr <= {next_field, mem_addr};
      ext_inst_addr <= {instruction_field_reg, program_counter};
      // Autoindex words live in the code field of each field
      autoindex_access <= cycle_defer & (mem_addr >= `MFE_AUTO_LO) &
        (mem_addr <= `MFE_AUTO_HI);
      pc_store_addr <= `MFE_PC_STORE;
      pc_resume_addr <= `MFE_PC_RESUME;
    end
  end

  // ------------------------------------------------------------
  // Accumulator transfer gating
  // ------------------------------------------------------------
  // Unused read codes give no load pulse, AC stays as is
  reg [11:0] next_ac;
  reg next_ac_load;
  always @* begin
    next_ac = ac_result;
    next_ac_load = 1'b0;
    if (do_read & (field_num == `MFE_RD_DATA)) begin
      next_ac = ac_with_field(working_register, operand_field_reg);
      next_ac_load = 1'b1;
    end else if (do_read & (field_num == `MFE_RD_IF)) begin
      next_ac = ac_with_field(working_register, instruction_field_reg);
      next_ac_load = 1'b1;
    end else if (do_read & (field_num == `MFE_RD_SB)) begin
      next_ac = ac_with_field(working_register, saved_field_pair[0]);
      next_ac[`MFE_AC_SB_HI:`MFE_AC_SB_LO] = 2'h0;
      next_ac[`MFE_AC_SF1] = saved_field_pair[1];
      next_ac_load = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ac_result <= `MFE_AC_RESET;
      ac_result_load <= 1'b0;
    end else begin
      ac_result <= next_ac;
      ac_result_load <= next_ac_load;
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite write channels
  // ------------------------------------------------------------
  // Address and data taken in either order, held until commit
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= `MFE_WORD0;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MFE_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        // Unmapped writes change nothing and answer an error
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (addr_known(aw_addr_q)) begin
          s_axi_bresp <= `MFE_RESP_OKAY;
        end else begin
          s_axi_bresp <= `MFE_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid & s_axi_bready) begin
        // Reopen only once the answer is gone
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control register: gates the instruction decoder
  always @(posedge aclk) begin
    if (!aresetn) begin
      io_enable <= `MFE_CTRL_RESET;
    end else if (ctrl_wr) begin
      io_enable <= w_data_q[`MFE_CTRL_IO_EN];
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite read channels
  // ------------------------------------------------------------
  // One read at a time; data sampled at the address handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `MFE_WORD0;
      s_axi_rresp <= `MFE_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= reg_read(s_axi_araddr);
      if (addr_known(s_axi_araddr)) begin
        s_axi_rresp <= `MFE_RESP_OKAY;
      end else begin
        s_axi_rresp <= `MFE_RESP_SLVERR;
      end
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> mfe_map.vh
`ifndef MFE_MAP_VH
`define MFE_MAP_VH
// ------------------------------------------------------------
// Instruction decode
// ------------------------------------------------------------
`define MFE_OP_IO 3'h6
`define MFE_DEV_SEL 3'h2
`define MFE_SEL_HI 8
`define MFE_SEL_LO 6
`define MFE_NUM_HI 5
`define MFE_NUM_LO 3
`define MFE_FN_BIT 3
`define MFE_IOP_HI 2
`define MFE_IOP_LO 0
`define MFE_IOP_DATA 0
`define MFE_IOP_CODE 1
`define MFE_IOP_READ 3'h4
`define MFE_RD_DATA 3'h1
`define MFE_RD_IF 3'h2
`define MFE_RD_SB 3'h3
`define MFE_RESTORE 3'h4
// ------------------------------------------------------------
// Accumulator bit positions (lsb numbering)
// ------------------------------------------------------------
`define MFE_AC_CLR_HI 5
`define MFE_AC_CLR_LO 4
`define MFE_AC_FIELD 3
`define MFE_AC_SB_HI 2
`define MFE_AC_SB_LO 1
`define MFE_AC_SF1 0
// ------------------------------------------------------------
// Addresses and reset values
// ------------------------------------------------------------
`define MFE_AUTO_LO 12'h008
`define MFE_AUTO_HI 12'h00F
`define MFE_PC_STORE 13'h0000
`define MFE_PC_RESUME 13'h0001
`define MFE_FIELD0 1'b0
`define MFE_SF_RESET 2'h0
`define MFE_AC_RESET 12'h000
// ------------------------------------------------------------
// Register map and bus answers
// ------------------------------------------------------------
`define MFE_REG_LOAD 8'h00
`define MFE_REG_STATUS 8'h04
`define MFE_REG_CTRL 8'h08
`define MFE_LD_CODE 0
`define MFE_LD_DATA 1
`define MFE_CTRL_IO_EN 0
`define MFE_CTRL_RESET 1'b1
`define MFE_RESP_OKAY 2'h0
`define MFE_RESP_SLVERR 2'h2
`define MFE_WORD0 32'h00000000
`endif

// >>> mfe_core_props.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the field extension core
// ----------------------------------------
module mfe_core_props (
  input wire aclk,
  input wire aresetn,
  input wire [2:0] opcode_register,
  input wire [11:0] memory_buffer,
  input wire [11:0] program_counter,
  input wire [11:0] mem_addr,
  input wire cycle_fetch,
  input wire cycle_defer,
  input wire io_pulse,
  input wire jump_op_done,
  input wire subroutine_call_op_done,
  input wire interrupt_entry,
  input wire [11:0] ac_result,
  input wire ac_result_load,
  input wire field_select,
  input wire [12:0] ext_mem_addr,
  input wire [12:0] ext_inst_addr,
  input wire autoindex_access,
  input wire interrupt_block,
  input wire [12:0] pc_store_addr,
  input wire [12:0] pc_resume_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Legal field I/O op on this cycle
  wire io_ok = io_pulse && cycle_fetch && opcode_register == 3'h6 && memory_buffer[8:6] == 3'h2;
  // Read codes 6214, 6224, 6234: field digit 1 to 3, restore excluded
  wire rd_io = io_ok && memory_buffer[2:0] == 3'h4 && memory_buffer[5:3] != 3'h0
    && memory_buffer[5:3] <= 3'h3;
  // Change-code request
  wire code_io = io_ok && memory_buffer[1];
  // Control transfer without a fresh change-code
  wire xfer = (jump_op_done || subroutine_call_op_done) && !code_io;
  // Defer cycle through an autoindex word
  wire auto_hit = cycle_defer && mem_addr >= 12'h008 && mem_addr <= 12'h00F;
  chk_read_pulse: assert property (rd_io |-> ##[1:2] ac_result_load)
    else $error("field read gave no accumulator load");
  chk_read_clear: assert property (ac_result_load |-> ac_result[5:4] == 2'h0)
    else $error("accumulator bits not cleared on field read");
  chk_block_set: assert property (code_io && !interrupt_entry |=> interrupt_block)
    else $error("interrupt block not raised");
  chk_block_hold: assert property (interrupt_block && !xfer && !interrupt_entry
    && !jump_op_done && !subroutine_call_op_done |=> interrupt_block)
    else $error("interrupt block dropped early");
  chk_block_clear: assert property (xfer |=> !interrupt_block)
    else $error("interrupt block kept after transfer");
  chk_pc_vectors: assert property (pc_store_addr == 13'h0000 && pc_resume_addr == 13'h0001)
    else $error("interrupt vectors wrong");
  chk_mem_addr: assert property ($past(aresetn) |-> ext_mem_addr == {field_select, $past(mem_addr)})
    else $error("extended memory address wrong");
  chk_inst_addr: assert property ($past(aresetn) |-> ext_inst_addr[11:0] == $past(program_counter))
    else $error("instruction address low part wrong");
  chk_auto_index: assert property ($past(aresetn) |-> autoindex_access == $past(auto_hit))
    else $error("autoindex flag wrong");
  chk_fetch_field: assert property ($past(aresetn) && $past(cycle_fetch)
    |-> field_select == ext_inst_addr[12])
    else $error("fetch not from code field");
  // Main scenarios reached
  cover property (interrupt_block ##1 !interrupt_block);
  cover property (autoindex_access);
  cover property (ac_result_load);
endmodule
bind mfe_core mfe_core_props chk (.aclk, .aresetn, .opcode_register, .memory_buffer,
  .program_counter, .mem_addr, .cycle_fetch, .cycle_defer, .io_pulse, .jump_op_done,
  .subroutine_call_op_done, .interrupt_entry, .ac_result, .ac_result_load, .field_select,
  .ext_mem_addr, .ext_inst_addr, .autoindex_access, .interrupt_block, .pc_store_addr,
  .pc_resume_addr);
`default_nettype wire

// >>> mfe_cpu.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Processor core and break device stand-in
// ----------------------------------------
module mfe_cpu (
  input wire logic aclk,
  output logic [2:0] opcode_register = 3'h0,
  output logic [11:0] memory_buffer = 12'h000,
  output logic [11:0] working_register = 12'h000,
  output logic [11:0] program_counter = 12'h000,
  output logic [11:0] mem_addr = 12'h000,
  output logic cycle_fetch = 1'b0,
  output logic cycle_defer = 1'b0,
  output logic cycle_execute = 1'b0,
  output logic cycle_break = 1'b0,
  output logic io_pulse = 1'b0,
  output logic jump_op_done = 1'b0,
  output logic subroutine_call_op_done = 1'b0,
  output logic interrupt_entry = 1'b0,
  output logic break_load_strobe = 1'b0,
  output logic break_addr_ext = 1'b0
);
  // One I/O pulse; opcode and fetch may be wrong on purpose
  task automatic iop(input logic [2:0] op, input logic f, input logic [11:0] mb,
    input logic [11:0] ac);
    @(posedge aclk);
    opcode_register <= op;
    cycle_fetch <= f;
    memory_buffer <= mb;
    working_register <= ac;
    io_pulse <= 1'b1;
    @(posedge aclk);
    io_pulse <= 1'b0;
    cycle_fetch <= 1'b0;
  endtask
  // Event pulse: 0 jump, 1 call, 2 interrupt entry
  task automatic ev(input logic [1:0] k);
    @(posedge aclk);
    jump_op_done <= k == 2'h0;
    subroutine_call_op_done <= k == 2'h1;
    interrupt_entry <= k == 2'h2;
    @(posedge aclk);
    jump_op_done <= 1'b0;
    subroutine_call_op_done <= 1'b0;
    interrupt_entry <= 1'b0;
  endtask
  // Break device hands over its field bit with the strobe
  task automatic brk(input logic ext);
    @(posedge aclk);
    break_addr_ext <= ext;
    break_load_strobe <= 1'b1;
    @(posedge aclk);
    break_load_strobe <= 1'b0;
    // Released line shows the inverse, not a stale copy
    break_addr_ext <= ~ext;
  endtask
  // Major state {fetch, defer, execute, break} set, then two cycles waited; held until the next call
  task automatic cyc(input logic [3:0] s, input logic [11:0] a);
    @(posedge aclk);
    {cycle_fetch, cycle_defer, cycle_execute, cycle_break} <= s;
    mem_addr <= a;
    program_counter <= a;
    repeat (2) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// >>> test_memory_field_extension.sv
`timescale 1ns/1ps
`default_nettype none
module test_memory_field_extension;
  // ----------------------------------------
  // Clock, reset, bus and core wiring
  // ----------------------------------------
  logic aclk, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] op;
  wire [11:0] mb, wr_ac, pc, ma, ac_result;
  wire cf, cd, ce, cb, iop, jd, sd, ie, bs, bx, ac_result_load, field_select;
  wire autoindex_access, interrupt_block;
  wire [12:0] ext_mem_addr, ext_inst_addr, pcs, pcr;
  int mismatches = 0;
  int checked = 0;
  mfe_cpu cpu (.aclk(aclk), .opcode_register(op), .memory_buffer(mb), .working_register(wr_ac),
    .program_counter(pc), .mem_addr(ma), .cycle_fetch(cf), .cycle_defer(cd),
    .cycle_execute(ce), .cycle_break(cb), .io_pulse(iop), .jump_op_done(jd),
    .subroutine_call_op_done(sd), .interrupt_entry(ie), .break_load_strobe(bs),
    .break_addr_ext(bx));
  mfe_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .opcode_register(op), .memory_buffer(mb), .working_register(wr_ac), .program_counter(pc),
    .mem_addr(ma), .cycle_fetch(cf), .cycle_defer(cd), .cycle_execute(ce), .cycle_break(cb),
    .io_pulse(iop), .jump_op_done(jd), .subroutine_call_op_done(sd), .interrupt_entry(ie),
    .break_load_strobe(bs), .break_addr_ext(bx), .ac_result(ac_result),
    .ac_result_load(ac_result_load), .field_select(field_select), .ext_mem_addr(ext_mem_addr),
    .ext_inst_addr(ext_inst_addr), .autoindex_access(autoindex_access),
    .interrupt_block(interrupt_block), .pc_store_addr(pcs), .pc_resume_addr(pcr));
  // 40 MHz clock
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ----------------------------------------
  // Compare, bus and verdict tasks
  // ----------------------------------------
  task automatic cmp_bus(input logic [31:0] gd, input logic [1:0] gr,
    input logic [31:0] ed, input logic [1:0] er);
    checked++;
    if (gd !== ed || gr !== er) begin
      mismatches++;
      $display("ERROR %0t bus got %h/%h want %h/%h", $time, gd, gr, ed, er);
    end
  endtask
  task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t core got %h want %h", $time, g, e);
    end
  endtask
  // Write: both channels offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    cmp_bus(32'h00000000, bresp, 32'h00000000, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    cmp_bus(rdata, rresp, ed, er);
  endtask
  // Accumulator answer, waited for a few cycles at most
  task automatic acchk(input logic [11:0] e);
    for (int i = 0; i < 4 && ac_result_load !== 1'b1; i++) @(negedge aclk);
    cmp_out({3'h0, ac_result_load, ac_result}, {4'h1, e});
  endtask
  // Drive one major state and check the chosen field
  task automatic fcase(input logic [3:0] s, input logic [11:0] a, input logic ai,
    input logic fs);
    cpu.cyc(s, a);
    @(negedge aclk);
    cmp_out({1'b0, autoindex_access, field_select, ext_mem_addr}, {1'b0, ai, fs, fs, a});
  endtask
  task automatic results;
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Hang guard, far beyond the fewer than two hundred cycles needed
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    results();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 32'h00000000, 2'h0);
    rd(8'h08, 32'h00000001, 2'h0);
    rd(8'h0C, 32'h00000000, 2'h2);
    wr(8'h0C, 32'h00000003, 2'h2);
    wr(8'h04, 32'h000000FF, 2'h0);
    // Wrong opcode, no fetch, wrong select: all ignored
    cpu.iop(3'h5, 1'b1, 12'hC89, 12'h000);
    cpu.iop(3'h6, 1'b0, 12'hC89, 12'h000);
    cpu.iop(3'h6, 1'b1, 12'hCC9, 12'h000);
    rd(8'h04, 32'h00000000, 2'h0);
    cpu.iop(3'h6, 1'b1, 12'hC89, 12'h000);
    rd(8'h04, 32'h00000002, 2'h0);
    // Core I/O ops switched off hold the operand field
    wr(8'h08, 32'h00000000, 2'h0);
    cpu.iop(3'h6, 1'b1, 12'hC81, 12'h000);
    rd(8'h04, 32'h00000002, 2'h0);
    wr(8'h08, 32'h00000001, 2'h0);
    // Lane 0 off: answered, but the gate stays on
    wstrb <= 4'hE;
    wr(8'h08, 32'h00000000, 2'h0);
    wstrb <= 4'hF;
    rd(8'h08, 32'h00000001, 2'h0);
    cpu.iop(3'h6, 1'b1, 12'hC8C, 12'hFF7);
    acchk(12'hFCF);
    cpu.iop(3'h6, 1'b1, 12'hC8A, 12'h000);
    rd(8'h04, 32'h00000046, 2'h0);
    cpu.iop(3'h6, 1'b1, 12'hC94, 12'hFF7);
    acchk(12'hFC7);
    rd(8'h04, 32'h00000046, 2'h0);
    cpu.ev(2'h1);
    rd(8'h04, 32'h00000007, 2'h0);
    cpu.iop(3'h6, 1'b1, 12'hC81, 12'h000);
    rd(8'h04, 32'h00000005, 2'h0);
    cpu.ev(2'h2);
    rd(8'h04, 32'h00000008, 2'h0);
    cmp_out({3'h0, pcs}, 16'h0000);
    cmp_out({3'h0, pcr}, 16'h0001);
    cpu.iop(3'h6, 1'b1, 12'hC9C, 12'hFFF);
    acchk(12'hFC8);
    cpu.iop(3'h6, 1'b1, 12'hCA4, 12'h000);
    rd(8'h04, 32'h0000000C, 2'h0);
    cpu.ev(2'h0);
    rd(8'h04, 32'h0000000D, 2'h0);
    cpu.cyc(4'h8, 12'hABC);
    @(negedge aclk);
    cmp_out({3'h0, ext_inst_addr}, 16'h1ABC);
    // Operand field 1, code field 0, break field 1
    wr(8'h00, 32'h00000002, 2'h0);
    cpu.brk(1'b1);
    rd(8'h04, 32'h0000002A, 2'h0);
    fcase(4'h8, 12'h123, 1'b0, 1'b0);
    fcase(4'h4, 12'h00F, 1'b1, 1'b0);
    fcase(4'h2, 12'h456, 1'b0, 1'b1);
    fcase(4'h1, 12'h789, 1'b0, 1'b1);
    fcase(4'h4, 12'h010, 1'b0, 1'b0);
    fcase(4'h8, 12'h008, 1'b0, 1'b0);
    fcase(4'h2, 12'h456, 1'b0, 1'b0);
    // Mid-run reset clears the set operand and break fields
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h04, 32'h00000000, 2'h0);
    results();
  end
endmodule
`default_nettype wire
